//--- core/burner_input_supervision.sv
// Burner safety input supervision: flame guard, high temperature, chain, lockout, fuel
//
// Overview of operation
// RL1: External flame guard setting: mains on multi-function input means flame.
// RL2: Redundancy contact on oil start release input carries inverse state.
// RL3: Flame loss from external guard reported only after at least 1.2 s; code reports after 1199 to 1200 ms.
// RL4: High-temperature signal during operation stops detector flame supervision.
// RL5: High-temperature signal gone during operation resumes detector supervision.
// RL6: High temperature in standby/startup skips tests, phase 22 jumps to 36.
// RL7: High temperature during shutdown: no detector flame supervision.
// RL8: Startup without high temperature: detector, stray-light test, purge, proving.
// RL9: Stray-light test can be disabled; reaction is lockout or start prevention.
// RL10: Safety chain loss shuts down; configurable restarts, then lockout.
// RL11: All chain contacts and flange switch form one chain indication.
// RL12: Open chain cuts fuel valve and ignition power regardless of sequencing.
// RL13: Installer keeps sub-second momentary contacts out of the safety chain.
// RL14: Escape and enter together force an unalterable lockout.
// RL15: In lockout, escape then enter from the display resets.
// RL16: In lockout, a 1 to 3 s button press resets; others ignored.
// RL17: Not locked out, a 1 to 6 s button press forces lockout.
// RL18: Reset clears alarm and fault, cancels lockout, restarts into standby.
// RL19: Wired fuel selector wins; internal position uses automation or display.
// RL20: Display factor maps stable flame to 100%, viewable and resettable.
// RL21: Inverse redundancy contact may accompany the high-temperature thermostat.
// RL22: Button press duration counted on a fixed tick, evaluated on release.
module burner_input_supervision
  import burner_sup_pkg::*;
#(
  parameter int CHAIN_N = 4,
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int FLAME_TICKS = FLAME_REACT_TICKS,
  parameter int MIN_TICKS = PRESS_MIN_TICKS,
  parameter int RESET_MAX = RESET_MAX_TICKS,
  parameter int LOCK_MAX = LOCK_MAX_TICKS
) (
  input wire logic clk_i, // 100 MHz system clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic mf_input_i, // Pin: mains on multi-function input
  input wire logic oil_start_release_input_i, // Pin: oil start release input
  input wire logic [CHAIN_N-1:0] chain_contacts_i, // Pins: series chain contacts
  input wire logic flange_switch_i, // Pin: burner flange end switch
  input wire logic reset_button_i, // Pin: terminal reset button, high pressed
  input wire logic fuel_sel_gas_i, // Pin: selector in gas position
  input wire logic fuel_sel_oil_i, // Pin: selector in oil position
  input wire logic [2:0] multi_function_input_select_i, // Config: input function
  input wire logic redundancy_contact_setting_i, // Config: release input is redundancy
  input wire logic stray_light_test_enable_i, // Config: stray-light test on
  input wire logic stray_light_reaction_i, // Config: 1 lockout, 0 start block
  input wire logic [REPEAT_W-1:0] safety_chain_repeat_count_i, // Config: restarts
  input wire logic prepurge_cfg_i, // Config: prepurging configured
  input wire logic valve_proving_cfg_i, // Config: valve proving configured
  input wire logic fuel_source_i, // Config: 1 automation link, 0 display
  input wire logic [1:0] building_automation_link_fuel_i, // Fuel from automation
  input wire logic [1:0] display_fuel_i, // Fuel from display unit
  input wire logic key_esc_i, // Display: escape key event pulse
  input wire logic key_enter_i, // Display: enter key event pulse
  input wire logic operating_i, // Sequencer: burner in operation
  input wire logic [7:0] phase_i, // Sequencer: present phase
  input wire logic detector_flame_i, // Detector: flame seen
  input wire logic stray_test_strobe_i, // Sequencer: stray-light sample pulse
  input wire logic valve_req_i, // Sequencer: fuel valves wanted on
  input wire logic ignition_req_i, // Sequencer: ignition wanted on
  input wire logic [7:0] flame_level_i, // Raw flame signal level
  input wire logic flame_stable_i, // Flame level is stable
  input wire logic standardize_i, // Pulse: compute display factor
  input wire logic scale_reset_i, // Pulse: reset display factor
  output logic flame_o, // Effective flame indication
  output logic flame_loss_o, // Flame loss reported to sequencer
  output logic redundancy_fault_o, // Redundancy contact not inverse
  output logic ht_active_o, // High-temperature mode in force
  output logic detector_supervision_o, // Detector supervision active
  output logic stray_test_request_o, // Run stray-light test this start
  output logic prepurge_enable_o, // Run prepurging this start
  output logic valve_proving_enable_o, // Run valve proving this start
  output logic skip_to_36_o, // Jump from phase 22 to phase 36
  output logic [7:0] next_phase_o, // Phase to enter after phase 22
  output logic start_block_o, // Start prevented by stray light
  output logic safety_chain_ok_o, // Combined chain indication
  output logic chain_shutdown_o, // Shutdown request from chain loss
  output logic valve_power_o, // Fuel valve power
  output logic ignition_power_o, // Ignition power
  output logic lockout_o, // Device in lockout
  output logic alarm_relay_o, // Alarm relay drive
  output logic fault_led_o, // Fault indication
  output logic restart_o, // Pulse: restart into standby
  output logic [1:0] fuel_o, // Selected fuel
  output logic [15:0] display_scale_factor_o, // Display factor, 8.8
  output logic [7:0] display_level_o // Scaled flame display, percent
);

  localparam int SW = CHAIN_N + 6;
  localparam int DW = $clog2(TICK_DIV);
  localparam int FW = $clog2(FLAME_TICKS + 1);

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic mf_s, rel_s, flange_s, btn_s, gas_s, oil_s;
  logic [CHAIN_N-1:0] chain_s;
  logic [DW-1:0] div_reg;
  logic tick;
  logic [FW-1:0] loss_reg;
  logic chain_ok_reg;
  logic [REPEAT_W:0] repeat_reg;
  logic esc_seen_reg;
  lock_state_t state_reg, state_next;
  logic btn_reset, btn_lock;
  logic ext_mode, ht_mode, red_used, guard_flame, red_ok, stray_lock;
  logic [15:0] factor_reg;
  logic [23:0] scaled;

  // Compute 100% factor for a given level; zero level keeps unity
  function automatic logic [15:0] scale_for(input logic [7:0] level);
    if (level == 8'h00)
      return SCALE_ONE;
    return SCALE_NUM / {8'h00, level};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and time base

  assign pins_raw = {fuel_sel_oil_i, fuel_sel_gas_i, reset_button_i, flange_switch_i,
                     oil_start_release_input_i, mf_input_i, chain_contacts_i};
  assign chain_s = pins_s[CHAIN_N-1:0];
  assign mf_s = pins_s[CHAIN_N];
  assign rel_s = pins_s[CHAIN_N+1];
  assign flange_s = pins_s[CHAIN_N+2];
  assign btn_s = pins_s[CHAIN_N+3];
  assign gas_s = pins_s[CHAIN_N+4];
  assign oil_s = pins_s[CHAIN_N+5];

  pin_sync #(.W(SW)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pins_raw),
    .sync_o(pins_s)
  );

  // Divider gives a one-cycle tick every millisecond
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_reg <= '0;
    else if (div_reg == DW'(TICK_DIV - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign tick = (div_reg == DW'(TICK_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Flame source and high-temperature mode

  assign ext_mode = (multi_function_input_select_i == EXTERNAL_FLAME_GUARD_SETTING);
  assign ht_mode = (multi_function_input_select_i == HIGH_TEMP_GUARD_SETTING);
  assign red_used = redundancy_contact_setting_i && (ext_mode || ht_mode);
  // Redundancy contact must read the opposite of the main contact [RL2] [RL21]
  assign red_ok = !red_used || (rel_s != mf_s);
  assign guard_flame = mf_s && red_ok; // [RL1]

  // High temperature suspends detector work in any state it is seen in
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ht_active_o <= 1'b0;
      detector_supervision_o <= 1'b1;
    end
    else
    begin
      ht_active_o <= ht_mode && mf_s && red_ok;
      detector_supervision_o <= !ext_mode && !(ht_mode && mf_s && red_ok); // [RL4] [RL5] [RL7]
    end
  end

  // Startup plan: tests run only when no high-temperature signal [RL6] [RL8]
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stray_test_request_o <= 1'b0;
      prepurge_enable_o <= 1'b0;
      valve_proving_enable_o <= 1'b0;
      skip_to_36_o <= 1'b0;
      next_phase_o <= PHASE_SKIP_FROM;
    end
    else
    begin
      stray_test_request_o <= stray_light_test_enable_i && !ht_active_o; // [RL9]
      prepurge_enable_o <= prepurge_cfg_i && !ht_active_o;
      valve_proving_enable_o <= valve_proving_cfg_i && !ht_active_o;
      skip_to_36_o <= ht_active_o && !operating_i && phase_i == PHASE_SKIP_FROM;
      next_phase_o <= (ht_active_o && !operating_i) ? PHASE_SKIP_TO : PHASE_SKIP_FROM + 8'h01;
    end
  end

  // Effective flame; external guard loss is held back for the reaction time.
  // Counting whole ticks means the real delay is FLAME_TICKS-1 to FLAME_TICKS ms.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      loss_reg <= '0;
    else if (!ext_mode || guard_flame)
      loss_reg <= '0;
    else if (tick && loss_reg != FW'(FLAME_TICKS))
      loss_reg <= loss_reg + 1'b1; // [RL3]
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flame_o <= 1'b0;
      flame_loss_o <= 1'b0;
      redundancy_fault_o <= 1'b0;
    end
    else
    begin
      flame_o <= ext_mode ? guard_flame : (detector_supervision_o && detector_flame_i);
      flame_loss_o <= ext_mode ? (loss_reg == FW'(FLAME_TICKS))
                               : (detector_supervision_o && operating_i && !detector_flame_i);
      redundancy_fault_o <= !red_ok;
    end
  end

  // Stray light: start block is held until a sample without flame, or a sample taken with the lockout reaction, clears it [RL9]
  assign stray_lock = stray_test_strobe_i && stray_test_request_o && detector_flame_i
                      && stray_light_reaction_i;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      start_block_o <= 1'b0;
    else if (stray_test_strobe_i && stray_test_request_o)
      start_block_o <= detector_flame_i && !stray_light_reaction_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safety chain

  // No debounce: chain contacts are assumed to stay put for over 1 s [RL13]
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      chain_ok_reg <= 1'b0;
    else
      chain_ok_reg <= (&chain_s) && flange_s; // [RL11]
  end
  assign safety_chain_ok_o = chain_ok_reg;
  assign chain_shutdown_o = !chain_ok_reg; // [RL10]

  // Power path bypasses the sequencer's intent once the chain opens
  assign valve_power_o = valve_req_i && chain_ok_reg && !lockout_o; // [RL12]
  assign ignition_power_o = ignition_req_i && chain_ok_reg && !lockout_o; // [RL12]

  // Count chain losses; past the allowed repeats the device locks out
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      repeat_reg <= '0;
    else if (state_reg == ST_RESET)
      repeat_reg <= {{REPEAT_W{1'b0}}, chain_ok_reg && !((&chain_s) && flange_s)};
    else if (chain_ok_reg && !((&chain_s) && flange_s) && repeat_reg[REPEAT_W] == 1'b0)
      repeat_reg <= repeat_reg + 1'b1; // [RL10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lockout and reset

  press_timer #(
    .MIN_TICKS(MIN_TICKS),
    .RESET_MAX(RESET_MAX),
    .LOCK_MAX(LOCK_MAX)
  ) u_press (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .pressed_i(btn_s),
    .locked_i(lockout_o),
    .reset_req_o(btn_reset),
    .lock_req_o(btn_lock)
  );

  // Escape alone arms the display reset; any other key disarms it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      esc_seen_reg <= 1'b0;
    else if (key_esc_i || key_enter_i)
      esc_seen_reg <= key_esc_i && !key_enter_i;
  end

  // Run state acts only on lock requests, lockout only on reset requests, so a reset in lockout wins over a lock request
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:
        if ((key_esc_i && key_enter_i) || btn_lock || stray_lock
            || repeat_reg > {1'b0, safety_chain_repeat_count_i}) // [RL14] [RL17] [RL10]
          state_next = ST_LOCK;
      ST_LOCK:
        if ((key_enter_i && !key_esc_i && esc_seen_reg) || btn_reset) // [RL15] [RL16]
          state_next = ST_RESET;
      ST_RESET:
        state_next = ST_RUN; // [RL18]
      default:
        state_next = ST_LOCK;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // Alarm and fault follow lockout; reset pulses the restart [RL18]
  assign lockout_o = (state_reg == ST_LOCK);
  assign alarm_relay_o = lockout_o;
  assign fault_led_o = lockout_o;
  assign restart_o = (state_reg == ST_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // Fuel selection and display scaling

  // Wired selector has priority over the internal sources [RL19]
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      fuel_o <= FUEL_NONE;
    else if (gas_s && !oil_s)
      fuel_o <= FUEL_GAS;
    else if (oil_s && !gas_s)
      fuel_o <= FUEL_OIL;
    else if (!gas_s && !oil_s)
      fuel_o <= fuel_source_i ? building_automation_link_fuel_i : display_fuel_i;
    else
      fuel_o <= FUEL_NONE;
  end

  // Factor only changes the display, never the flame signal itself [RL20]
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      factor_reg <= SCALE_ONE;
    else if (scale_reset_i)
      factor_reg <= SCALE_ONE;
    else if (standardize_i && flame_stable_i)
      factor_reg <= scale_for(flame_level_i); // [RL20]
  end
  assign display_scale_factor_o = factor_reg;

  assign scaled = {16'h0000, flame_level_i} * {8'h00, factor_reg};
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      display_level_o <= 8'h00;
    else if (scaled[23:16] != 8'h00)
      display_level_o <= DISPLAY_SAT;
    else
      display_level_o <= scaled[15:8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_valve_cut: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
    !chain_ok_reg |-> !valve_power_o && !ignition_power_o)
    else $error("Fuel or ignition powered with open chain");

  a_key_lock: assert property (@(posedge clk_i) disable iff (rst_i) // [RL14]
    key_esc_i && key_enter_i && state_reg == ST_RUN |=> lockout_o && alarm_relay_o)
    else $error("Escape plus enter did not lock out");

  a_reset_exit: assert property (@(posedge clk_i) disable iff (rst_i) // [RL18]
    restart_o |-> !alarm_relay_o && !fault_led_o ##1 state_reg == ST_RUN)
    else $error("Reset did not clear alarm and return to run");

  a_ht_supv: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    ht_active_o |-> !detector_supervision_o)
    else $error("Detector supervision kept in high temperature");

  a_ht_resume: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    ht_mode && $stable(multi_function_input_select_i) && $fell(ht_active_o)
    |-> detector_supervision_o)
    else $error("Detector supervision not resumed");

  a_phase_skip: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    ht_active_o && !operating_i && phase_i == PHASE_SKIP_FROM |=> skip_to_36_o)
    else $error("Phase 22 not skipped to 36");

  a_flame_delay: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    $rose(flame_loss_o) && ext_mode |-> $past(loss_reg) == FW'(FLAME_TICKS))
    else $error("External flame loss reported early");

  a_chain_shut: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
    !chain_ok_reg |-> chain_shutdown_o)
    else $error("Chain loss without shutdown");

  a_fuel_gas: assert property (@(posedge clk_i) disable iff (rst_i) // [RL19]
    gas_s && !oil_s |=> fuel_o == FUEL_GAS)
    else $error("Gas selector position not obeyed");

  a_scale_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [RL20]
    scale_reset_i |=> display_scale_factor_o == SCALE_ONE)
    else $error("Display factor not reset");

endmodule

//--- core/burner_sup_pkg.sv
// Shared constants, codes and timing counts for burner input supervision
package burner_sup_pkg;

  // Clock and internal time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = 1;

  // Timing figures in milliseconds and their tick counts
  localparam int FLAME_REACT_MS = 1200;
  localparam int FLAME_REACT_TICKS = (FLAME_REACT_MS + TICK_MS - 1) / TICK_MS;
  localparam int PRESS_MIN_MS = 1000;
  localparam int PRESS_MIN_TICKS = (PRESS_MIN_MS + TICK_MS - 1) / TICK_MS;
  localparam int RESET_MAX_MS = 3000;
  localparam int RESET_MAX_TICKS = RESET_MAX_MS / TICK_MS;
  localparam int LOCK_MAX_MS = 6000;
  localparam int LOCK_MAX_TICKS = LOCK_MAX_MS / TICK_MS;

  // Multi-function input settings
  localparam logic [2:0] MF_DEACTIVATED = 3'h0;
  localparam logic [2:0] EXTERNAL_FLAME_GUARD_SETTING = 3'h1;
  localparam logic [2:0] HIGH_TEMP_GUARD_SETTING = 3'h2;

  // Sequencer phases: 22 jumps straight to 36 under high temperature
  localparam logic [7:0] PHASE_SKIP_FROM = 8'h16;
  localparam logic [7:0] PHASE_SKIP_TO = 8'h24;

  // Fuel codes
  localparam logic [1:0] FUEL_NONE = 2'h0;
  localparam logic [1:0] FUEL_GAS = 2'h1;
  localparam logic [1:0] FUEL_OIL = 2'h2;

  // Display scaling: factor is unsigned 8.8 fixed point
  localparam logic [15:0] SCALE_ONE = 16'h0100;
  localparam logic [15:0] SCALE_NUM = 16'h6400;
  localparam logic [7:0] DISPLAY_SAT = 8'hff;

  // Restart repetitions counter width
  localparam int REPEAT_W = 4;

  // Lockout state machine
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_LOCK = 3'h2,
    ST_RESET = 3'h4
  } lock_state_t;

endpackage

//--- core/pin_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic [W-1:0] pin_i, // Raw pin levels
  output logic [W-1:0] sync_o // Synchronised levels
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_o <= meta_reg;
    end
  end

endmodule

//--- core/press_timer.sv
// Terminal reset-button press duration measurement and window check
module press_timer
  import burner_sup_pkg::*;
#(
  parameter int MIN_TICKS = PRESS_MIN_TICKS,
  parameter int RESET_MAX = RESET_MAX_TICKS,
  parameter int LOCK_MAX = LOCK_MAX_TICKS
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic tick_i, // Time base enable pulse
  input wire logic pressed_i, // Synchronised button level
  input wire logic locked_i, // Device is in lockout
  output logic reset_req_o, // Pulse: valid reset press released
  output logic lock_req_o // Pulse: valid manual lockout press released
);

  localparam int CW = $clog2(LOCK_MAX + 2);
  localparam logic [CW-1:0] SAT = CW'(LOCK_MAX + 1);

  logic [CW-1:0] dur_reg;
  logic pressed_reg;
  logic release_p;

  assign release_p = pressed_reg && !pressed_i;

  // Duration counter starts on press, saturates above the longest window [RL22]
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      dur_reg <= '0;
    else if (!pressed_i)
      dur_reg <= '0;
    else if (tick_i && dur_reg != SAT)
      dur_reg <= dur_reg + 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pressed_reg <= 1'b0;
    else
      pressed_reg <= pressed_i;
  end

  // Window evaluated on release; out-of-window presses do nothing
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reset_req_o <= 1'b0;
      lock_req_o <= 1'b0;
    end
    else
    begin
      reset_req_o <= release_p && locked_i && dur_reg >= CW'(MIN_TICKS)
                     && dur_reg <= CW'(RESET_MAX); // [RL16]
      lock_req_o <= release_p && !locked_i && dur_reg >= CW'(MIN_TICKS)
                    && dur_reg <= CW'(LOCK_MAX); // [RL17]
    end
  end

  a_short_press: assert property (@(posedge clk_i) disable iff (rst_i)
    release_p && dur_reg < CW'(MIN_TICKS) |=> !reset_req_o && !lock_req_o) // [RL16]
    else $error("Short button press was acted on");

  a_long_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    release_p && locked_i && dur_reg > CW'(RESET_MAX) |=> !reset_req_o) // [RL16]
    else $error("Over-long press reset the lockout");

  a_lock_window: assert property (@(posedge clk_i) disable iff (rst_i)
    release_p && !locked_i && dur_reg >= CW'(MIN_TICKS) && dur_reg <= CW'(LOCK_MAX)
    |=> lock_req_o) // [RL17]
    else $error("Valid lockout press not acted on");

endmodule

//--- bench/field_model.sv
// Field-side model: chain contacts, flange switch, reset button and guard contacts
module field_model (
  input wire logic clk_i, // Bench clock
  output logic mf_o, // Multi-function input
  output logic rel_o, // Oil start release input
  output logic [3:0] chain_o, // Series chain contacts
  output logic flange_o, // Flange end switch
  output logic button_o // Terminal reset button
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // Chain closed and button idle from time zero
  initial
  begin
    {mf_o, rel_o, button_o} = 3'h0;
    chain_o = 4'hf;
    flange_o = 1'b1;
  end
  // Second contact always inverse, so a welded contact shows as a fault
  task automatic guard(input logic lit);
    mf_o = lit;
    rel_o = !lit;
  endtask
  // Press held for whole ticks of ten cycles
  task automatic push(input int ticks);
    button_o = 1'b1;
    repeat (ticks * 10) @(negedge clk_i);
    button_o = 1'b0;
  endtask
  // A chain contact stays open: never a momentary opening
  task automatic open_chain(input int idx);
    chain_o[idx] = 1'b0;
  endtask
endmodule

//--- bench/burner_input_supervision_tb.sv
// Self-checking bench for burner input supervision
module burner_input_supervision_tb;
  import burner_sup_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, fuel_sel_gas_i, fuel_sel_oil_i, redundancy_contact_setting_i;
  logic stray_light_test_enable_i, stray_light_reaction_i, prepurge_cfg_i, valve_proving_cfg_i;
  logic fuel_source_i, key_esc_i, key_enter_i, operating_i, detector_flame_i, valve_req_i;
  logic stray_test_strobe_i, ignition_req_i, flame_stable_i, standardize_i, scale_reset_i;
  logic flame_o, flame_loss_o, redundancy_fault_o, ht_active_o, detector_supervision_o;
  logic stray_test_request_o, prepurge_enable_o, valve_proving_enable_o, skip_to_36_o;
  logic start_block_o, safety_chain_ok_o, chain_shutdown_o, valve_power_o, ignition_power_o;
  logic lockout_o, alarm_relay_o, fault_led_o, restart_o;
  logic [3:0] safety_chain_repeat_count_i;
  logic [2:0] multi_function_input_select_i;
  logic [1:0] building_automation_link_fuel_i, display_fuel_i, fuel_o;
  logic [7:0] phase_i, flame_level_i, next_phase_o, display_level_o;
  logic [15:0] display_scale_factor_o, lf = 16'h0041;
  wire logic mf_input_i, oil_start_release_input_i, flange_switch_i, reset_button_i;
  wire logic [3:0] chain_contacts_i;
  int miscompares = 0, checked = 0, lock_m = 1;
  int fq[$] = '{1, 2, 1, 2}, pq[$] = '{20, 5, 45, 40, 25};
  ////////////////////////////////////////////////////////////////////////////////
  // Shortened time base: one tick is ten cycles
  burner_input_supervision #(.TICK_DIV(10), .FLAME_TICKS(12), .MIN_TICKS(10),
    .RESET_MAX(30), .LOCK_MAX(60)) dut (.*);
  field_model fm (.clk_i, .mf_o(mf_input_i), .rel_o(oil_start_release_input_i),
    .chain_o(chain_contacts_i), .flange_o(flange_switch_i), .button_o(reset_button_i));
  always #5 clk_i = ~clk_i;
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence, inputs moved at the falling edge
  initial
  begin
    {redundancy_contact_setting_i, stray_light_test_enable_i, stray_light_reaction_i} = 3'h0;
    {fuel_sel_gas_i, fuel_sel_oil_i, fuel_source_i, key_esc_i, key_enter_i} = 5'h0;
    {operating_i, detector_flame_i, stray_test_strobe_i, standardize_i, scale_reset_i} = 5'h0;
    {prepurge_cfg_i, valve_proving_cfg_i, valve_req_i, ignition_req_i, flame_stable_i} = 5'h0c;
    {safety_chain_repeat_count_i, multi_function_input_select_i, phase_i} = '0;
    {building_automation_link_fuel_i, display_fuel_i} = 4'h9;
    flame_level_i = 8'(rnd()) | 8'h01;
    cyc(6);
    rst_i = 0;
    cyc(4);
    chk("chain_ok", safety_chain_ok_o, 1);
    chk("power", {valve_power_o, ignition_power_o}, 2);
    {standardize_i, flame_stable_i, ignition_req_i} = 3'h7;
    cyc(1);
    standardize_i = 0;
    cyc(2);
    chk("factor", display_scale_factor_o, 16'h6400 / flame_level_i);
    chk("display", display_level_o, flame_level_i * (25600 / flame_level_i) / 256);
    scale_reset_i = 1;
    cyc(1);
    scale_reset_i = 0;
    cyc(2);
    chk("factor", display_scale_factor_o, SCALE_ONE);
    for (int i = 0; i < 4; i++)
    begin
      {fuel_sel_gas_i, fuel_sel_oil_i} = 2'(2 >> i);
      fuel_source_i = (i == 3);
      cyc(4);
      chk("fuel", fuel_o, fq[i]);
    end
    multi_function_input_select_i = EXTERNAL_FLAME_GUARD_SETTING;
    redundancy_contact_setting_i = 1;
    fm.guard(1);
    cyc(4);
    chk("flame", {flame_o, redundancy_fault_o}, 2);
    fm.guard(0);
    cyc(100);
    chk("flame_loss", flame_loss_o, 0);
    cyc(60);
    chk("flame_loss", flame_loss_o, 1);
    multi_function_input_select_i = HIGH_TEMP_GUARD_SETTING;
    phase_i = PHASE_SKIP_FROM;
    {stray_light_test_enable_i, prepurge_cfg_i} = 2'h3;
    fm.guard(1);
    cyc(6);
    chk("ht", {ht_active_o, detector_supervision_o, prepurge_enable_o}, 4);
    chk("ht_stray", stray_test_request_o, 0);
    chk("next", {skip_to_36_o, next_phase_o}, {1'b1, PHASE_SKIP_TO});
    fm.guard(0);
    operating_i = 1;
    cyc(6);
    chk("startup", {detector_supervision_o, prepurge_enable_o}, 3);
    chk("startup", {stray_test_request_o, ignition_power_o}, 3);
    {key_esc_i, key_enter_i} = 2'h3;
    cyc(1);
    {key_esc_i, key_enter_i} = 2'h0;
    cyc(2);
    chk("lock", {lockout_o, alarm_relay_o, fault_led_o}, 7);
    key_esc_i = 1;
    cyc(1);
    {key_esc_i, key_enter_i} = 2'h1;
    cyc(1);
    key_enter_i = 0;
    chk("reset", {restart_o, lockout_o, alarm_relay_o, fault_led_o}, 8);
    // Stray light first blocks the start, then locks out once the reaction says so
    {detector_flame_i, stray_test_strobe_i} = 2'h3;
    cyc(1);
    chk("block", start_block_o, 1);
    stray_light_reaction_i = 1;
    cyc(1);
    stray_test_strobe_i = 0;
    chk("stray", {start_block_o, lockout_o}, 1);
    foreach (pq[i])
    begin
      fm.push(pq[i]);
      cyc(6);
      if (pq[i] >= 10 && pq[i] <= (lock_m ? 30 : 60))
        lock_m = !lock_m;
      chk("button", lockout_o, lock_m);
    end
    fm.open_chain(rnd() % 4);
    cyc(4);
    chk("chain", {safety_chain_ok_o, chain_shutdown_o, valve_power_o}, 2);
    cyc(2);
    chk("chain_lock", lockout_o, 1);
    conclude();
  end
  // Watchdog well past the expected run of about 1600 cycles
  initial
  begin
    #100us;
    miscompares++;
    conclude();
  end
endmodule
